// ==== hw/pgs_consts.svh ====
// Purpose: constants of the power-good timer and skip control block
// Assumes: 100 MHz system clock
// Notes:   times are kept in their own unit, cycle counts derive from them
`ifndef PGS_CONSTS_SVH
`define PGS_CONSTS_SVH
`define PGS_CLK_HZ      100000000
`define PGS_POR_MS      2
`define PGS_POR_CYC     (`PGS_POR_MS * (`PGS_CLK_HZ / 1000))
`define PGS_FLT_NS      6500
`define PGS_FLT_CYC     ((`PGS_FLT_NS * (`PGS_CLK_HZ / 1000000)) / 1000)
`define PGS_FSW_KHZ     1600
`define PGS_PER_CYC     (`PGS_CLK_HZ / (`PGS_FSW_KHZ * 1000))
`define PGS_ZC_ENTER    8
`define PGS_CTRL_OFS    12'h000
`define PGS_STAT_OFS    12'h004
`define PGS_CTRL_RST    2'h0
`define PGS_CTRL_FPWM   0
`define PGS_CTRL_SWRST  1
`define PGS_ST_WIN      0
`define PGS_ST_POR      1
`define PGS_ST_SKIP     2
`define PGS_ST_EN       3
`define PGS_ST_ZC_LSB   4
`define PGS_ST_SW_LSB   8
`endif

// ==== hw/pgs_pkg.sv ====
// Purpose: types of the power-good timer and skip control block
// Assumes: nothing
// Notes:   comparator and pin inputs travel as one packed struct
package pgs_pkg;
   typedef enum logic [1:0] {SW_OFF, SW_HS, SW_LS, SW_IDLE} pgs_sw_e;
   typedef struct packed {
      logic lo_rise;   // above 92 % of nominal
      logic lo_fall;   // below 88 %
      logic hi_rise;   // above 112 %
      logic hi_fall;   // below 107 %
      logic ipk_trip;  // pwm current comparator
      logic zc;        // low-side current crossed zero
      logic i20_trip;  // high-side current at 20 % of limit
      logic vo_hi15;   // output 1.5 % above nominal
      logic vo_nom;    // output at or below nominal
      logic vo_lo15;   // output 1.5 % below nominal
      logic en;        // enable pin
      logic skip_sel;  // light-load mode select pin
      logic mr;        // manual reset input
   } pgs_in_s;
endpackage : pgs_pkg

// ==== hw/pgs_top.sv ====
// Purpose: power-good delay timer, window filter and switching sequencer
// Assumes: comparators and pins are level inputs, one 100 MHz clock
// Notes:   apb slave with zero wait states, pready always high
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns
`include "pgs_consts.svh"

module pgs_top
   import pgs_pkg::*;
#(
   parameter int POR_CYC = `PGS_POR_CYC
) (
   input  wire logic          sys_clk_i,            // system clock
   input  wire logic          rst_i,                // async reset, active high
   input  wire pgs_in_s       cmp_i,                // comparators and pins
   input  wire logic          manual_reset_input_i, // raw manual reset pin
   output logic               por_good_o,           // power-good, high when good
   output logic               hs_on_o,              // high-side switch on
   output logic               ls_on_o,              // low-side switch on
   output logic               discharge_o,          // output discharge on
   output logic               skip_mode_o,          // pulse-skip mode active
   input  wire logic          psel_i,               // apb select
   input  wire logic          penable_i,            // apb enable
   input  wire logic          pwrite_i,             // apb write
   input  wire logic [11:0]   paddr_i,              // apb byte address
   input  wire logic [31:0]   pwdata_i,             // apb write data
   output logic [31:0]        prdata_o,             // apb read data
   output logic               pready_o,             // apb ready
   output logic               pslverr_o             // apb error
);
   localparam int FLT_CYC = `PGS_FLT_CYC;
   localparam int PER_CYC = `PGS_PER_CYC;
   localparam int IW      = $bits(pgs_in_s);

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [IW-1:0] s1_q;
   logic [IW-1:0] s2_q;
   pgs_in_s       in_s;

   genvar gi;
   generate
      for (gi = 0; gi < IW; gi++) begin : g_sync
         always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
               s1_q[gi] <= 1'b0;
               s2_q[gi] <= 1'b0;
            end else begin
               s1_q[gi] <= cmp_i[gi];
               s2_q[gi] <= s1_q[gi];
            end
         end
      end
   endgenerate
   assign in_s = pgs_in_s'(s2_q);

   // ****************************************************************
   // apb registers
   // ****************************************************************
   logic [1:0]  ctrl_q;
   logic        force_pwm;
   logic        mr_eff;
   logic        skip_ok;
   logic        en_s;
   logic        win_q;
   logic        por_q;
   logic        skip_q;
   logic [3:0]  zc_cnt_q;
   pgs_sw_e     st_q;
   logic        stat_hit;
   logic        ctrl_hit;

   assign en_s      = in_s.en;
   assign force_pwm = ctrl_q[`PGS_CTRL_FPWM];
   assign mr_eff    = in_s.mr | ctrl_q[`PGS_CTRL_SWRST];
   assign skip_ok   = in_s.skip_sel & ~force_pwm;
   assign ctrl_hit  = paddr_i == `PGS_CTRL_OFS;
   assign stat_hit  = paddr_i == `PGS_STAT_OFS;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~ctrl_hit & ~stat_hit;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= `PGS_CTRL_RST;
      end else if (psel_i && penable_i && pwrite_i && ctrl_hit) begin
         ctrl_q <= pwdata_i[1:0];
      end
   end

   // read data is captured in the setup cycle
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0;
      end else if (psel_i && !penable_i) begin
         prdata_o <= 32'h0;
         if (ctrl_hit) begin
            prdata_o[1:0] <= ctrl_q;
         end else if (stat_hit) begin
            prdata_o[`PGS_ST_WIN]  <= win_q;
            prdata_o[`PGS_ST_POR]  <= por_q;
            prdata_o[`PGS_ST_SKIP] <= skip_q;
            prdata_o[`PGS_ST_EN]   <= en_s;
            prdata_o[`PGS_ST_ZC_LSB +: 4] <= zc_cnt_q;
            prdata_o[`PGS_ST_SW_LSB +: 2] <= st_q;
         end
      end
   end

   // ****************************************************************
   // window comparators and filter
   // ****************************************************************
   logic       lo_ok_q;
   logic       hi_bad_q;
   logic       win_raw;
   logic [9:0] flt_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lo_ok_q  <= 1'b0;
         hi_bad_q <= 1'b0;
      end else begin
         if (in_s.lo_rise) begin
            lo_ok_q <= 1'b1;
         end else if (in_s.lo_fall) begin
            lo_ok_q <= 1'b0;
         end
         if (in_s.hi_rise) begin
            hi_bad_q <= 1'b1;
         end else if (in_s.hi_fall) begin
            hi_bad_q <= 1'b0;
         end
      end
   end
   assign win_raw = lo_ok_q & ~hi_bad_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         win_q <= 1'b0;
         flt_q <= 10'h0;
      end else if (win_raw == win_q) begin
         flt_q <= 10'h0;
      end else if (flt_q == 10'(FLT_CYC - 1)) begin
         win_q <= win_raw;
         flt_q <= 10'h0;
      end else begin
         flt_q <= flt_q + 10'h1;
      end
   end

   // ****************************************************************
   // power-good delay timer
   // ****************************************************************
   logic [17:0] por_cnt_q;
   logic        por_clr;

   assign por_clr = ~en_s | mr_eff | ~win_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         por_cnt_q <= 18'h0;
         por_q     <= 1'b0;
      end else if (por_clr) begin
         por_cnt_q <= 18'h0;
         por_q     <= 1'b0;
      end else if (por_cnt_q == 18'(POR_CYC - 1)) begin
         por_q     <= 1'b1;
      end else begin
         por_cnt_q <= por_cnt_q + 18'h1;
      end
   end
   // raw pin gates the output so a reset needs no clock edge
   assign por_good_o = por_q & ~manual_reset_input_i;

   // ****************************************************************
   // switching cycle clock and sequencer
   // ****************************************************************
   logic [5:0] per_q;
   logic       tick;
   logic       hold_q;
   logic       zc_seen_q;
   pgs_sw_e    st_d;

   assign tick = per_q == 6'(PER_CYC - 1);

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         per_q <= 6'h0;
      end else if (!en_s || tick) begin
         per_q <= 6'h0;
      end else begin
         per_q <= per_q + 6'h1;
      end
   end

   always_comb begin
      st_d = st_q;
      if (!en_s) begin
         st_d = SW_OFF;
      end else if (tick) begin
         st_d = (skip_q && hold_q) ? SW_IDLE : SW_HS;
      end else begin
         unique case (st_q)
            SW_OFF, SW_IDLE: begin
               st_d = st_q;
            end
            SW_HS: begin
               if (in_s.ipk_trip) begin
                  st_d = SW_LS;
               end else if (skip_q && (in_s.i20_trip || in_s.vo_hi15)) begin
                  st_d = SW_LS;
               end
            end
            SW_LS: begin
               if (skip_q && in_s.zc) begin
                  st_d = SW_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= SW_OFF;
      end else begin
         st_q <= st_d;
      end
   end

   // burst halt after overshoot until output is back at nominal
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hold_q <= 1'b0;
      end else if (!skip_q) begin
         hold_q <= 1'b0;
      end else if (in_s.vo_hi15) begin
         hold_q <= 1'b1;
      end else if (in_s.vo_nom) begin
         hold_q <= 1'b0;
      end
   end

   // ****************************************************************
   // zero-cross counting and skip mode
   // ****************************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         zc_seen_q <= 1'b0;
      end else if (!en_s || tick) begin
         zc_seen_q <= 1'b0;
      end else if (st_q == SW_LS && in_s.zc) begin
         zc_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         zc_cnt_q <= 4'h0;
         skip_q   <= 1'b0;
      end else if (!en_s || !skip_ok) begin
         zc_cnt_q <= 4'h0;
         skip_q   <= 1'b0;
      end else if (skip_q) begin
         zc_cnt_q <= 4'h0;
         if (in_s.vo_lo15) begin
            skip_q <= 1'b0;
         end
      end else if (tick) begin
         if (!zc_seen_q) begin
            zc_cnt_q <= 4'h0;
         end else if (zc_cnt_q == 4'(`PGS_ZC_ENTER - 1)) begin
            zc_cnt_q <= 4'h0;
            skip_q   <= 1'b1;
         end else begin
            zc_cnt_q <= zc_cnt_q + 4'h1;
         end
      end
   end

   assign hs_on_o     = st_q == SW_HS;
   assign ls_on_o     = st_q == SW_LS;
   assign discharge_o = ~en_s;
   assign skip_mode_o = skip_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_overshoot;
      skip_q && st_q == SW_HS && in_s.vo_hi15 && !tick && en_s;
   endsequence

   property p_mr_clear;
      mr_eff |=> !por_q;
   endproperty
   a_mr_clear: assert property (p_mr_clear) else $error("manual reset kept power-good");

   property p_mr_now;
      manual_reset_input_i |-> !por_good_o;
   endproperty
   a_mr_now: assert property (p_mr_now) else $error("power-good high under reset");

   property p_por_delay;
      $rose(por_q) |-> $past(win_q) && $past(por_cnt_q) == 18'(POR_CYC - 1);
   endproperty
   a_por_delay: assert property (p_por_delay) else $error("power-good before delay");

   property p_filter;
      win_q != $past(win_q) |-> $past(flt_q) == 10'(FLT_CYC - 1);
   endproperty
   a_filter: assert property (p_filter) else $error("window change not filtered");

   property p_skip_entry;
      $rose(skip_q) |-> $past(zc_cnt_q) == 4'h7 && $past(tick);
   endproperty
   a_skip_entry: assert property (p_skip_entry) else $error("skip entered early");

   property p_zc_clear;
      tick && !zc_seen_q && !skip_q |=> zc_cnt_q == 4'h0;
   endproperty
   a_zc_clear: assert property (p_zc_clear) else $error("zero-cross count kept");

   property p_forced;
      !skip_ok |=> !skip_q;
   endproperty
   a_forced: assert property (p_forced) else $error("skip while pwm forced");

   property p_disable;
      !en_s |=> !hs_on_o && !ls_on_o && !por_q && zc_cnt_q == 4'h0;
   endproperty
   a_disable: assert property (p_disable) else $error("activity while disabled");

   property p_hs_start;
      $rose(hs_on_o) |-> $past(tick);
   endproperty
   a_hs_start: assert property (p_hs_start) else $error("high side off clock");

   property p_ls_hold;
      !skip_q && st_q == SW_LS && !tick && en_s |=> st_q == SW_LS;
   endproperty
   a_ls_hold: assert property (p_ls_hold) else $error("low side left early");

   property p_overshoot;
      s_overshoot |=> st_q == SW_LS ##1 !hs_on_o;
   endproperty
   a_overshoot: assert property (p_overshoot) else $error("pulse not ended");

   property p_skip_exit;
      skip_q && in_s.vo_lo15 |=> !skip_q;
   endproperty
   a_skip_exit: assert property (p_skip_exit) else $error("skip not left");

endmodule : pgs_top

// ==== verification/pgs_host.sv ====
// Purpose: host side model driving enable, mode select and manual reset pins
// Assumes: pins change right after a rising clock edge
// Notes:   pins never float, each has a level from time zero
`timescale 1ns/1ns
// ****************************************
// host pins
// ****************************************
module pgs_host (
   input  wire logic sys_clk_i, // system clock
   output logic      en_o,      // enable pin
   output logic      skip_o,    // mode select pin
   output logic      mr_o       // manual reset pin
);
   initial begin
      en_o   = 1'b0;
      skip_o = 1'b0;
      mr_o   = 1'b0;
   end
   task automatic drive(input logic en, input logic skip, input logic mr);
      @(posedge sys_clk_i);
      en_o   <= en;
      skip_o <= skip;
      mr_o   <= mr;
   endtask : drive
endmodule : pgs_host

// ==== verification/power_good_timer_and_skip_control_bench.sv ====
// Purpose: self-checking bench of the power-good timer and skip control
// Assumes: outputs are read at the rising edge, before that edge's updates
// Notes:   short power-good count for run time
`timescale 1ns/1ns
`include "pgs_consts.svh"
// ****************************************
// bench
// ****************************************
module power_good_timer_and_skip_control_bench;
   import pgs_pkg::*;
   localparam int         POR   = 50;
   localparam int         PER   = `PGS_PER_CYC;
   localparam logic [3:0] WSTEP [6] = '{4'h1, 4'h5, 4'h9, 4'h8, 4'ha, 4'h9};
   localparam logic [5:0] WEXP  = 6'h2d;
   logic        sys_clk_i;
   logic        rst_i;
   pgs_in_s     ana;
   pgs_in_s     cmp;
   logic        h_en;
   logic        h_skip;
   logic        h_mr;
   logic        por;
   logic        hs;
   logic        ls;
   logic        dis;
   logic        skp;
   logic        psel;
   logic        pen;
   logic        pwr;
   logic [11:0] padr;
   logic [31:0] pwd;
   logic [31:0] prd;
   logic        prdy;
   logic        perr;
   logic [31:0] rd;
   logic        er;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cyc_cnt  = 0;
   int          n;
   int          m;
   integer      seed;

   always_comb begin
      cmp          = ana;
      cmp.en       = h_en;
      cmp.skip_sel = h_skip;
      cmp.mr       = h_mr;
   end

   pgs_host i_host (.sys_clk_i(sys_clk_i), .en_o(h_en), .skip_o(h_skip), .mr_o(h_mr));

   pgs_top #(.POR_CYC(POR)) i_dut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmp_i(cmp), .manual_reset_input_i(h_mr),
      .por_good_o(por), .hs_on_o(hs), .ls_on_o(ls), .discharge_o(dis), .skip_mode_o(skp),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
      .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr));

   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   function automatic logic [31:0] ctrl_exp(input logic [31:0] w);
      return {30'h0, w[1:0]};
   endfunction : ctrl_exp

   task automatic close_out;
      if (n_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   always @(posedge sys_clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         n_errors++;
         close_out;
      end
   end

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk_i);
   endtask : tick

   task automatic chk1(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1

   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk32

   task automatic chkn(input string nm, input int lo, input int hi, input int g);
      n_checks++;
      if (g < lo || g > hi) begin
         n_errors++;
         $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask : chkn

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge sys_clk_i);
      psel <= 1'b1;
      pen  <= 1'b0;
      pwr  <= wr;
      padr <= a;
      pwd  <= wd;
      @(posedge sys_clk_i);
      pen <= 1'b1;
      // only the bench timeout ends a slave that never answers
      do begin
         @(posedge sys_clk_i);
      end while (prdy !== 1'b1);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb

   // counts edges until the high side is seen switching on again
   task automatic hs_rise(output int c);
      c = 0;
      while (hs === 1'b1 && c < 200) begin
         tick(1);
         c++;
      end
      while (hs !== 1'b1 && c < 200) begin
         tick(1);
         c++;
      end
   endtask : hs_rise

   initial begin
      seed = 32'h4c9a4b52;
      rst_i = 1'b1;
      ana = '0;
      ana.hi_fall = 1'b1;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      padr = 12'h000;
      pwd = 32'h0;
      tick(10);
      chk1("rst_por", 1'b0, por);
      chk1("rst_dis", 1'b1, dis);
      rst_i <= 1'b0;
      i_host.drive(1'b1, 1'b0, 1'b0);
      ana.lo_rise <= 1'b1;
      tick(600);
      chk1("por_early", 1'b0, por);
      tick(120);
      chk1("por_good", 1'b1, por);
      for (int i = 0; i < 6; i++) begin
         {ana.lo_rise, ana.lo_fall, ana.hi_rise, ana.hi_fall} <= WSTEP[i];
         tick(720);
         chk1("por_window", WEXP[i], por);
      end
      n = 5 + ($random(seed) & 7);
      i_host.drive(1'b1, 1'b0, 1'b1);
      #1 chk1("por_mr", 1'b0, por);
      tick(n);
      i_host.drive(1'b1, 1'b0, 1'b0);
      tick(POR - 5);
      chk1("por_restart", 1'b0, por);
      tick(15);
      chk1("por_after_mr", 1'b1, por);
      apb(1'b1, `PGS_CTRL_OFS, 32'hffffffff);
      tick(4);
      chk1("por_swrst", 1'b0, por);
      apb(1'b0, `PGS_CTRL_OFS, 32'h0);
      chk32("ctrl", ctrl_exp(32'hffffffff), rd);
      apb(1'b1, `PGS_CTRL_OFS, 32'h0);
      apb(1'b0, `PGS_STAT_OFS, 32'h0);
      chk32("stat", 32'h9, rd & 32'h9);
      apb(1'b0, 12'h008, 32'h0);
      chk32("unmapped", 32'h0, rd);
      chk1("slverr", 1'b1, er);
      ana.zc <= 1'b1;
      // one current trip makes the high side fall so the next rise marks a cycle start
      ana.ipk_trip <= 1'b1;
      tick(8);
      ana.ipk_trip <= 1'b0;
      hs_rise(n);
      for (int i = 0; i < 10; i++) begin
         n = 4 + ($random(seed) & 31);
         tick(n);
         ana.ipk_trip <= 1'b1;
         tick(4);
         chk1("ls_on", 1'b1, ls);
         chk1("hs_off", 1'b0, hs);
         ana.ipk_trip <= 1'b0;
         hs_rise(m);
         chkn("pwm_period", PER, PER, n + 4 + m);
      end
      chk1("skip_forced", 1'b0, skp);
      i_host.drive(1'b1, 1'b1, 1'b0);
      ana.ipk_trip <= 1'b1;
      tick(5 * PER);
      ana.zc <= 1'b0;
      tick(2 * PER);
      chk1("skip_early", 1'b0, skp);
      ana.zc <= 1'b1;
      hs_rise(n);
      tick(PER / 2);
      chk1("ls_hold", 1'b1, ls);
      n = n + PER / 2;
      while (skp !== 1'b1 && n < 12 * PER) begin
         tick(1);
         n++;
      end
      chkn("skip_entry", 7 * PER, 9 * PER, n);
      ana.ipk_trip <= 1'b0;
      ana.i20_trip <= 1'b1;
      ana.zc <= 1'b0;
      hs_rise(n);
      tick(4);
      chk1("skip_hs_off", 1'b0, hs);
      // overshoot must land while the high side is on, with no current trip
      ana.i20_trip <= 1'b0;
      hs_rise(n);
      tick(8);
      ana.vo_hi15 <= 1'b1;
      ana.zc <= 1'b1;
      tick(4);
      chk1("skip_hs_ovr", 1'b0, hs);
      tick(4);
      chk1("idle_ls", 1'b0, ls);
      hs_rise(n);
      chkn("idle", 200, 200, n);
      ana.vo_hi15 <= 1'b0;
      ana.vo_nom <= 1'b1;
      hs_rise(n);
      chkn("resume", 1, PER + 4, n);
      ana.vo_lo15 <= 1'b1;
      tick(4);
      chk1("skip_exit", 1'b0, skp);
      i_host.drive(1'b0, 1'b1, 1'b0);
      tick(4);
      chk1("dis_en_low", 1'b1, dis);
      chk1("por_en_low", 1'b0, por);
      chk1("hs_en_low", 1'b0, hs);
      chk1("ls_en_low", 1'b0, ls);
      close_out;
   end
endmodule : power_good_timer_and_skip_control_bench
